/* pkg/prr_pkg.sv */
`default_nettype none
package prr_pkg;
  // command encodings on the simplified command bus
  localparam logic [2:0] CMD_NOP        = 3'h0;
  localparam logic [2:0] CMD_MODE_WRITE = 3'h1;
  localparam logic [2:0] CMD_READ       = 3'h2;
  localparam logic [2:0] CMD_READ_AP    = 3'h3;
  localparam logic [2:0] CMD_PRECHARGE  = 3'h4;
  localparam logic [2:0] CMD_ACTIVATE   = 3'h5;
  localparam logic [2:0] CMD_PAT_WRITE  = 3'h6;
  // mode register selectors
  localparam logic [1:0] MR_ZERO  = 2'h0;
  localparam logic [1:0] MR_THREE = 2'h3;
  // mode_reg_three field positions
  localparam int MR3_PAGE_LSB  = 0;
  localparam int MR3_ENABLE    = 2;
  localparam int MR3_FMT_LSB   = 11;
  // mode_reg_five read bus inversion enable bit
  localparam int MR5_RD_INV    = 12;
  // column address bits
  localparam int COL_BURST_CHOP = 12;
  localparam int COL_NIBBLE_HI  = 2;
  // read formats
  localparam logic [1:0] FMT_SERIAL    = 2'h0;
  localparam logic [1:0] FMT_PARALLEL  = 2'h1;
  localparam logic [1:0] FMT_STAGGERED = 2'h2;
  localparam logic [1:0] FMT_RESERVED  = 2'h3;
  // mode_reg_zero burst length field value asking for burst-chop bit high
  localparam logic [1:0] MR0_BL_OTF = 2'h1;
  // page 0 defaults, locations 0..3
  localparam logic [7:0] PAGE0_LOC0_RST = 8'h55;
  localparam logic [7:0] PAGE0_LOC1_RST = 8'h33;
  localparam logic [7:0] PAGE0_LOC2_RST = 8'h0F;
  localparam logic [7:0] PAGE0_LOC3_RST = 8'h00;
  // timing in ns at 40 ns clock
  localparam int CLK_NS          = 40;
  localparam int T_RP_NS         = 15;
  localparam int T_MRD_NS        = 80;
  localparam int T_MOD_NS        = 120;
  localparam int T_CCD_S_NS      = 160;
  localparam int T_CCD_L_NS      = 200;
  localparam int T_MPRR_NS       = 40;
  localparam int RP_CYC    = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int MRD_CYC   = (T_MRD_NS + CLK_NS - 1) / CLK_NS;
  localparam int MOD_CYC   = (T_MOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CCDS_CYC  = (T_CCD_S_NS + CLK_NS - 1) / CLK_NS;
  localparam int CCDL_CYC  = (T_CCD_L_NS + CLK_NS - 1) / CLK_NS;
  localparam int MPRR_CYC  = (T_MPRR_NS + CLK_NS - 1) / CLK_NS;
  // read latency parts in clocks
  localparam int ADD_LAT_DEF = 0;
  localparam int COL_LAT_DEF = 4;
  localparam int BEATS       = 8;
endpackage
`default_nettype wire

/* pkg/prr_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface prr_if #(parameter int DQ_W = 16) (input wire logic CLK_SYS);
  logic [2:0]      cmd;      // command code, valid one cycle
  logic [1:0]      mr_sel;   // mode register selector
  logic [1:0]      bank;     // bank address bits 1:0
  logic            bg;       // bank group bit
  logic [17:0]     addr;     // address bits
  logic [DQ_W-1:0] dq_o;     // data from device
  logic            dq_oe;    // device drives data
  logic            dqs_o;    // strobe from device
  logic            dqs_oe;   // device drives strobe
  modport dev (input cmd, mr_sel, bank, bg, addr, output dq_o, dq_oe, dqs_o, dqs_oe);
  modport ctl (output cmd, mr_sel, bank, bg, addr, input dq_o, dq_oe, dqs_o, dqs_oe);
endinterface
`default_nettype wire

/* logic/prr_dev.sv */
// Functional notes
// - pattern reads use fixed eight or four beats
// - bus inversion ignored in pattern readout
// - chopped reads start column 000 or 100
// - page 0 defaults after reset, writable
// - page 0 reads allow short spacing
// - pages 1-3 need long spacing
// - lock, precharge all, wait before entry
// - mode_reg_three bit 2 set enters readout
// - format 00 serial 01 parallel 10 staggered (format 10 is driven as serial here)
// - page field selects page 0 to 3
// - wait command and update delays
// - bank bits pick location 0 to 3
// - burst-chop bit high when field is 01
// - column bit 2 picks nibble order
// - low column bits zero, rest ignored
// - data after additive plus column latency
// - controller may repeat location reads
// - wait recovery before exit write
// - bit 2 clear exits, then update delay
// - serial format for mode-register contents
// - strobes driven with pattern data
// - serial: all lanes same, bit 7 first
// - parallel: location 0 byte every beat
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module prr_dev
  import prr_pkg::*;
#(
  parameter int DQ_W    = 16,
  parameter int ADD_LAT = ADD_LAT_DEF,
  parameter int COL_LAT = COL_LAT_DEF
)(
  input  wire logic CLK_SYS,        // system clock
  input  wire logic RST,            // async reset, high
  prr_if.dev        LNK,            // command and data link
  output logic [1:0] PAGE,          // selected page
  output logic       READOUT,       // readout mode active
  input  wire logic [7:0] PAGE1_LOC [4], // page 1 contents
  input  wire logic [7:0] PAGE2_LOC [4], // page 2 contents
  input  wire logic [7:0] PAGE3_LOC [4]  // page 3 contents
);
  localparam int LAT = ADD_LAT + COL_LAT;
  if (DQ_W % 8 != 0 || DQ_W < 8 || LAT < 1 || LAT > 30)
  begin : g_bad_param
    $error("prr_dev: unsupported parameters");
  end

  typedef struct packed {
    logic            mode_en;
    logic [1:0]      page;
    logic [1:0]      fmt;
    logic [1:0]      mr0_bl;
    logic [4:0]      lat_cnt;
    logic            pend;
    logic [7:0]      pend_byte;
    logic            pend_chop;
    logic            pend_hi;
    logic [3:0]      beat;
    logic [7:0]      data;
    logic            chop;
    logic            hi;
    logic [3:0][7:0] p0;
    logic [DQ_W-1:0] dq;
    logic            dq_oe;
    logic            dqs;
    logic            dqs_oe;
  } prr_dev_st_t;

  prr_dev_st_t st_r;
  prr_dev_st_t st_nxt;

  function automatic logic [7:0] loc_byte(input prr_dev_st_t s, input logic [1:0] loc,
                                          input logic [7:0] p1 [4], input logic [7:0] p2 [4],
                                          input logic [7:0] p3 [4]);
    unique case (s.page)
      2'h0:    loc_byte = s.p0[loc];
      2'h1:    loc_byte = p1[loc];
      2'h2:    loc_byte = p2[loc];
      2'h3:    loc_byte = p3[loc];
    endcase
  endfunction

  always_comb
  begin
    logic [2:0] idx;
    logic       bit_v;
    idx    = 3'h0;
    bit_v  = 1'b0;
    st_nxt = st_r;
    if (LNK.cmd == CMD_MODE_WRITE && LNK.mr_sel == MR_THREE)
    begin
      st_nxt.mode_en = LNK.addr[MR3_ENABLE];
      st_nxt.fmt     = LNK.addr[MR3_FMT_LSB +: 2];
      st_nxt.page    = LNK.addr[MR3_PAGE_LSB +: 2];
    end
    if (LNK.cmd == CMD_MODE_WRITE && LNK.mr_sel == MR_ZERO)
      st_nxt.mr0_bl = LNK.addr[1:0];
    if (LNK.cmd == CMD_PAT_WRITE && st_r.mode_en && st_r.page == 2'h0)
      st_nxt.p0[LNK.bank] = LNK.addr[7:0];
    // bank group, autoprecharge and column bits 1:0 are ignored
    if (st_r.mode_en && (LNK.cmd == CMD_READ || LNK.cmd == CMD_READ_AP))
    begin
      st_nxt.pend      = 1'b1;
      st_nxt.lat_cnt   = 5'(LAT - 1);
      st_nxt.pend_byte = (st_r.fmt == FMT_PARALLEL) ?
                         loc_byte(st_r, 2'h0, PAGE1_LOC, PAGE2_LOC, PAGE3_LOC) :
                         loc_byte(st_r, LNK.bank, PAGE1_LOC, PAGE2_LOC, PAGE3_LOC);
      // fixed burst setting: chop taken from the column bit
      st_nxt.pend_chop = (st_r.mr0_bl != MR0_BL_OTF) && !LNK.addr[COL_BURST_CHOP];
      st_nxt.pend_hi   = LNK.addr[COL_NIBBLE_HI];
    end
    else if (st_r.pend)
    begin
      if (st_r.lat_cnt == 5'h0)
      begin
        st_nxt.pend  = 1'b0;
        st_nxt.beat  = 4'h1;
        st_nxt.data  = st_r.pend_byte;
        st_nxt.chop  = st_r.pend_chop;
        st_nxt.hi    = st_r.pend_hi;
      end
      else
        st_nxt.lat_cnt = st_r.lat_cnt - 5'h1;
    end
    if (st_r.pend && st_r.lat_cnt == 5'h0)
      st_nxt.beat = 4'h1;
    else if (st_r.beat != 4'h0)
      st_nxt.beat = (st_r.beat == 4'(BEATS)) ? 4'h0 : st_r.beat + 4'h1;
    st_nxt.dq_oe  = 1'b0;
    st_nxt.dqs_oe = 1'b0;
    st_nxt.dq     = '0;
    st_nxt.dqs    = 1'b0;
    if (st_nxt.beat != 4'h0)
    begin
      idx   = 3'(st_nxt.beat - 4'h1);
      if (st_nxt.chop && st_nxt.hi)
        idx = idx + 3'h4;
      // no inversion: mode_reg_five bus inversion setting not consulted
      bit_v = st_nxt.data[3'h7 - idx];
      if (st_nxt.fmt == FMT_PARALLEL)
        st_nxt.dq = {(DQ_W/8){st_nxt.data}};
      else
        st_nxt.dq = {DQ_W{bit_v}};
      // chopped bursts leave beats 4..7 terminated (undriven)
      st_nxt.dq_oe  = !(st_nxt.chop && st_nxt.beat > 4'h4);
      st_nxt.dqs_oe = st_nxt.dq_oe;
      st_nxt.dqs    = st_nxt.beat[0];
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      st_r    <= '0;
      st_r.p0 <= {PAGE0_LOC3_RST, PAGE0_LOC2_RST, PAGE0_LOC1_RST, PAGE0_LOC0_RST};
    end
    else
      st_r <= st_nxt;
  end

  assign LNK.dq_o   = st_r.dq;
  assign LNK.dq_oe  = st_r.dq_oe;
  assign LNK.dqs_o  = st_r.dqs;
  assign LNK.dqs_oe = st_r.dqs_oe;
  assign PAGE       = st_r.page;
  assign READOUT    = st_r.mode_en;
endmodule // prr_dev
`default_nettype wire

/* logic/prr_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
module prr_ctl
  import prr_pkg::*;
#(
  parameter int DQ_W = 16
)(
  input  wire logic            CLK_SYS,    // system clock
  input  wire logic            RST,        // async reset, high
  prr_if.ctl                   LNK,        // command and data link
  input  wire logic            START,      // one-cycle: read one location
  input  wire logic [1:0]      PAGE,       // page to read
  input  wire logic [1:0]      LOC,        // location to read
  input  wire logic [1:0]      FMT,        // read format
  input  wire logic            CHOP,       // chopped four-beat read
  input  wire logic            HI_NIB,     // second nibble (bits 3:0) for chopped read
  input  wire logic            DLL_LOCKED, // delay-locked loop ready
  output logic                 BUSY,       // sequence running
  output logic                 DONE,       // one-cycle: data captured
  output logic [7:0]           RD_BYTE     // captured lane 0 bits
);
  if (DQ_W < 8)
  begin : g_bad_param
    $error("prr_ctl: unsupported width");
  end
  typedef enum {S_IDLE, S_PRE, S_ENTER, S_RD, S_CAP, S_EXIT, S_FIN} prr_ctl_state_t;
  typedef struct packed {
    prr_ctl_state_t st;
    logic [5:0] cnt;
    logic [3:0] bits;
    logic [7:0] sh;
    logic [2:0] cmd;
    logic [1:0] mr;
    logic [1:0] bank;
    logic [17:0] addr;
    logic busy;
    logic done;
    logic [7:0] rd;
  } prr_ctl_s_t;
  prr_ctl_s_t s_r;
  prr_ctl_s_t s_nxt;

  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.cmd  = CMD_NOP;
    s_nxt.mr   = 2'h0;
    s_nxt.bank = 2'h0;
    s_nxt.addr = '0;
    s_nxt.done = 1'b0;
    if (s_r.cnt != 6'h0)
      s_nxt.cnt = s_r.cnt - 6'h1;
    unique case (s_r.st)
      S_IDLE:
        if (START && DLL_LOCKED)
        begin
          s_nxt.st   = S_PRE;
          s_nxt.busy = 1'b1;
          s_nxt.cmd  = CMD_PRECHARGE;
          s_nxt.cnt  = 6'(RP_CYC);
        end
      S_PRE:
        if (s_r.cnt == 6'h0)
        begin
          s_nxt.st   = S_ENTER;
          s_nxt.cmd  = CMD_MODE_WRITE;
          s_nxt.mr   = MR_THREE;
          s_nxt.addr[MR3_ENABLE] = 1'b1;
          s_nxt.addr[MR3_FMT_LSB +: 2] = FMT;
          s_nxt.addr[MR3_PAGE_LSB +: 2] = PAGE;
          s_nxt.cnt  = 6'((MRD_CYC > MOD_CYC) ? MRD_CYC : MOD_CYC);
        end
      S_ENTER:
        if (s_r.cnt == 6'h0)
        begin
          s_nxt.st   = S_RD;
          s_nxt.cmd  = CMD_READ;
          s_nxt.bank = LOC;
          s_nxt.addr[COL_BURST_CHOP] = !CHOP;
          s_nxt.addr[COL_NIBBLE_HI]  = CHOP & HI_NIB;
          // spacing long enough for any page
          s_nxt.cnt  = 6'(CCDL_CYC);
          s_nxt.bits = 4'h0;
        end
      S_RD:
        if (LNK.dq_oe)
        begin
          s_nxt.sh   = {s_r.sh[6:0], LNK.dq_o[0]};
          s_nxt.bits = s_r.bits + 4'h1;
          if (s_r.bits == 4'(CHOP ? 3 : 7))
            s_nxt.st = S_CAP;
        end
      S_CAP:
        begin
          s_nxt.rd   = CHOP ? {4'h0, s_r.sh[3:0]} : s_r.sh;
          s_nxt.done = 1'b1;
          s_nxt.st   = S_EXIT;
          s_nxt.cnt  = 6'(MPRR_CYC + 4);
        end
      S_EXIT:
        if (s_r.cnt == 6'h0)
        begin
          s_nxt.st   = S_FIN;
          s_nxt.cmd  = CMD_MODE_WRITE;
          s_nxt.mr   = MR_THREE;
          s_nxt.cnt  = 6'(MOD_CYC);
        end
      S_FIN:
        if (s_r.cnt == 6'h0)
        begin
          s_nxt.st   = S_IDLE;
          s_nxt.busy = 1'b0;
        end
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      s_r    <= '0;
      s_r.st <= S_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  assign LNK.cmd    = s_r.cmd;
  assign LNK.mr_sel = s_r.mr;
  assign LNK.bank   = s_r.bank;
  assign LNK.bg     = 1'b0;
  assign LNK.addr   = s_r.addr;
  assign BUSY       = s_r.busy;
  assign DONE       = s_r.done;
  assign RD_BYTE    = s_r.rd;
endmodule // prr_ctl
`default_nettype wire

/* testbench/prr_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module prr_chk_sva
  import prr_pkg::*;
#(
  parameter int DQ_W = 16
)(
  input wire logic            CLK_SYS, // clock
  input wire logic            RST,     // async reset
  input wire logic [2:0]      cmd,     // command code
  input wire logic [1:0]      mr_sel,  // mode register
  input wire logic [17:0]     addr,    // address
  input wire logic [DQ_W-1:0] dq_o,    // device data
  input wire logic            dq_oe,   // data driven
  input wire logic            dqs_oe   // strobe driven
);
  localparam int LAT = ADD_LAT_DEF + COL_LAT_DEF;
  // first beat is launched LAT edges after the read edge, so it is sampled one edge later
  localparam int LAT_SEEN = LAT + 1;
  logic       rd;
  logic       mw3;
  logic       on_r;
  logic       ser_r;
  logic       pg0_r;
  logic [3:0] mw_gap_r;
  logic [3:0] rd_gap_r;
  logic [3:0] pre_gap_r;
  logic [3:0] oe_gap_r;
  assign rd  = (cmd == CMD_READ) || (cmd == CMD_READ_AP);
  assign mw3 = (cmd == CMD_MODE_WRITE) && (mr_sel == MR_THREE);
  // saturating cycle counts since the last event of each kind
  function automatic logic [3:0] inc(logic [3:0] v);
    return (v == 4'hF) ? v : v + 4'h1;
  endfunction
  always_ff @(posedge CLK_SYS or posedge RST)
    if (RST)
    begin
      on_r      <= 1'b0;
      ser_r     <= 1'b1;
      pg0_r     <= 1'b1;
      mw_gap_r  <= 4'hF;
      rd_gap_r  <= 4'hF;
      pre_gap_r <= 4'hF;
      oe_gap_r  <= 4'hF;
    end
    else
    begin
      mw_gap_r  <= mw3 ? 4'h0 : inc(mw_gap_r);
      rd_gap_r  <= rd ? 4'h0 : inc(rd_gap_r);
      pre_gap_r <= (cmd == CMD_PRECHARGE) ? 4'h0 : inc(pre_gap_r);
      oe_gap_r  <= dq_oe ? 4'h0 : inc(oe_gap_r);
      if (mw3)
      begin
        on_r  <= addr[MR3_ENABLE];
        ser_r <= addr[MR3_FMT_LSB +: 2] != FMT_PARALLEL;
        pg0_r <= addr[MR3_PAGE_LSB +: 2] == 2'h0;
      end
    end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence s_rd_in;
    on_r && rd;
  endsequence
  sequence s_burst;
    dq_oe[*4];
  endsequence
  a_read_latency: assert property (s_rd_in |-> ##LAT_SEEN $rose(dq_oe))
    else $error("burst start not at read latency");
  a_burst_len: assert property ($rose(dq_oe) |-> s_burst ##1 (s_burst or !dq_oe))
    else $error("burst not four or eight beats");
  a_serial_lanes: assert property (dq_oe && ser_r |-> dq_o == {DQ_W{dq_o[0]}})
    else $error("serial lanes differ");
  a_strobe_data: assert property (dq_oe |-> dqs_oe)
    else $error("data without strobe");
  a_entry_prech: assert property (mw3 && addr[MR3_ENABLE] |-> pre_gap_r >= RP_CYC - 1 && pre_gap_r != 4'hF)
    else $error("entry without precharge wait");
  a_mode_settle: assert property ((rd || cmd == CMD_ACTIVATE) |-> mw_gap_r >= MOD_CYC - 1)
    else $error("command too soon after mode write");
  a_read_space: assert property ((s_rd_in and (!pg0_r)) |-> rd_gap_r >= CCDL_CYC - 1)
    else $error("short read spacing on page above 0");
  a_exit_recov: assert property (mw3 && on_r && !addr[MR3_ENABLE] |-> !dq_oe && oe_gap_r >= MPRR_CYC - 1)
    else $error("exit before recovery");
  a_low_cols: assert property (s_rd_in |-> addr[1:0] == 2'h0)
    else $error("low column bits not zero");
  a_read_inmode: assert property (rd |-> on_r)
    else $error("read outside readout");
  a_par_bytes: assert property (dq_oe && !ser_r |-> dq_o == {(DQ_W/8){dq_o[7:0]}})
    else $error("parallel byte lanes differ");
endmodule // prr_chk_sva
`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import prr_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic       start = 1'b0;
  logic       chop = 1'b0;
  logic       hi_nib = 1'b0;
  logic       dll_locked = 1'b1;
  logic [1:0] page = 2'h0;
  logic [1:0] loc = 2'h0;
  logic [1:0] fmt = 2'h0;
  logic [1:0] dev_page;
  logic       busy;
  logic       done;
  logic       readout;
  logic       seen;
  logic [7:0] rd_byte;
  logic [7:0] got;
  logic [7:0] p1 [4] = '{8'h96, 8'hC3, 8'h3C, 8'h69};
  logic [7:0] p2 [4] = '{8'hE1, 8'h1E, 8'h7E, 8'h81};
  logic [7:0] p3 [4] = '{8'hF0, 8'h5A, 8'hA5, 8'hCC};
  logic [7:0] pat [4][4];
  int         bad_count = 0;
  int         total_checks = 0;
  prr_if #(.DQ_W(16)) lnk (.CLK_SYS(clk_sys));
  prr_dev #(.DQ_W(16)) prr_dev_inst (.CLK_SYS(clk_sys), .RST(rst), .LNK(lnk), .PAGE(dev_page),
    .READOUT(readout), .PAGE1_LOC(p1), .PAGE2_LOC(p2), .PAGE3_LOC(p3));
  prr_ctl #(.DQ_W(16)) prr_ctl_inst (.CLK_SYS(clk_sys), .RST(rst), .LNK(lnk), .START(start),
    .PAGE(page), .LOC(loc), .FMT(fmt), .CHOP(chop), .HI_NIB(hi_nib), .DLL_LOCKED(dll_locked),
    .BUSY(busy), .DONE(done), .RD_BYTE(rd_byte));
  prr_chk_sva #(.DQ_W(16)) prr_chk_sva_inst (.CLK_SYS(clk_sys), .RST(rst), .cmd(lnk.cmd),
    .mr_sel(lnk.mr_sel), .addr(lnk.addr), .dq_o(lnk.dq_o), .dq_oe(lnk.dq_oe),
    .dqs_oe(lnk.dqs_oe));
  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic check(string what, logic [7:0] exp, logic [7:0] seen_v);
    total_checks++;
    if (seen_v !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen_v);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one full entry, read, exit sequence; byte is taken at the done pulse
  task automatic read_loc(logic [1:0] pg, logic [1:0] lc, logic [1:0] fm, logic ch, logic hn);
    int n;
    page <= pg;
    loc <= lc;
    fmt <= fm;
    chop <= ch;
    hi_nib <= hn;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 300)
    begin
      @(posedge clk_sys);
      n++;
    end
    got = rd_byte;
    check("done seen", 8'h01, {7'h0, done});
    check("device page", {6'h0, pg}, {6'h0, dev_page});
    while (busy !== 1'b0 && n < 300)
    begin
      @(posedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    check("readout left", 8'h00, {7'h0, readout});
  endtask
  initial
  begin
    pat[0] = '{PAGE0_LOC0_RST, PAGE0_LOC1_RST, PAGE0_LOC2_RST, PAGE0_LOC3_RST};
    pat[1] = p1;
    pat[2] = p2;
    pat[3] = p3;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    for (int pg = 0; pg < 4; pg++)
    begin
      for (int lc = 0; lc < 4; lc++)
      begin
        read_loc(pg[1:0], lc[1:0], FMT_SERIAL, 1'b0, 1'b0);
        check("serial byte", pat[pg][lc], got);
      end
    end
    $display("test serial pages done");
    read_loc(2'h1, 2'h2, FMT_SERIAL, 1'b1, 1'b0);
    check("chop low", {4'h0, p1[2][7:4]}, got);
    read_loc(2'h1, 2'h2, FMT_SERIAL, 1'b1, 1'b1);
    check("chop high", {4'h0, p1[2][3:0]}, got);
    read_loc(2'h2, 2'h3, FMT_STAGGERED, 1'b0, 1'b0);
    check("staggered", p2[3], got);
    read_loc(2'h0, 2'h0, FMT_PARALLEL, 1'b0, 1'b0);
    check("parallel repeat", {8{PAGE0_LOC0_RST[0]}}, got);
    $display("test formats done");
    dll_locked <= 1'b0;
    seen = 1'b0;
    // a start while the loop is unlocked is refused outright
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    repeat (12)
    begin
      @(posedge clk_sys);
      seen = seen | (lnk.cmd !== CMD_NOP) | busy;
    end
    check("entry without lock", 8'h00, {7'h0, seen});
    dll_locked <= 1'b1;
    read_loc(2'h0, 2'h1, FMT_SERIAL, 1'b0, 1'b0);
    check("read after lock", pat[0][1], got);
    $display("test lock wait done");
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check("reset readout", 8'h00, {7'h0, readout});
    check("reset busy", 8'h00, {7'h0, busy});
    rst <= 1'b0;
    @(posedge clk_sys);
    read_loc(2'h0, 2'h3, FMT_SERIAL, 1'b0, 1'b0);
    check("after reset", pat[0][3], got);
    $display("test mid reset done");
    tally_and_finish();
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    $display("[ERR] watchdog expected finish seen timeout");
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
